// File: design/ppt_pkg.sv
/*
 * Shared constants and types of the parallel port timing, address and status block.
 * Assumes a single 40 MHz system clock that also serves as the peripheral clock.
 */
package ppt_pkg;

    // ------------------------------------------------------------
    // Register map (word indices, byte address is four times)
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] IDX_MODE = 4'h0;
    localparam logic [3:0] IDX_ADDR = 4'h1;
    localparam logic [3:0] IDX_PEN = 4'h2;
    localparam logic [3:0] IDX_STAT = 4'h3;
    localparam logic [3:0] IDX_CTRL = 4'h4;
    localparam logic [3:0] IDX_IBUF = 4'h5;
    localparam logic [3:0] IDX_OUTPUT_UNDERFLOW = 4'h6;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_BUSY = 15;
    localparam int MODE_IRQ_LSB = 13;
    localparam int MODE_INC_LSB = 11;
    localparam int MODE_MODE_LSB = 8;
    localparam int MODE_SETUP_LSB = 6;
    localparam int MODE_STROBE_LSB = 2;
    localparam int MODE_HOLD_LSB = 0;
    localparam int ADDR_BIT14 = 14;
    localparam int STAT_IALL = 15;
    localparam int STAT_IOVF = 14;
    localparam int STAT_IFULL_LSB = 8;
    localparam int STAT_OALL = 7;
    localparam int STAT_OUNF = 6;
    localparam int CTRL_CSF_LSB = 6;
    localparam int CTRL_MUX_LSB = 11;

    // ------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] MODE_WMASK = 32'h0000_7bff;
    localparam logic [31:0] ADDR_WMASK = 32'h0000_47ff;
    localparam logic [31:0] PEN_WMASK = 32'h0000_47ff;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_18c0;
    localparam logic [10:0] STEP_MASK = 11'h7fc;
    localparam logic [3:0] OEMPTY_RST = 4'hf;
    localparam logic [3:0] IFULL_RST = 4'h0;
    localparam logic [1:0] CSF_CHIPSEL = 2'h2;
    localparam logic [1:0] IRQ_EACH = 2'h1;
    localparam logic [1:0] STEP_UP = 2'h1;
    localparam logic [1:0] STEP_DOWN = 2'h2;
    localparam logic [1:0] MUX_NONE = 2'h0;
    localparam logic [1:0] MODE_LEGACY = 2'h0;
    localparam logic [1:0] MODE_ENH = 2'h1;

    typedef enum logic [1:0] {
        PPT_SLAVE_LEGACY,
        PPT_SLAVE_ENH,
        PPT_MASTER_SPLIT,
        PPT_MASTER_COMBINED
    } ppt_mode_e;

    typedef enum {PPT_IDLE, PPT_ADDRPH, PPT_SETUP, PPT_STROBE, PPT_HOLD} ppt_state_e;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ppt_req_s;

    // External host access to a slave buffer
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] sel;
        logic [7:0] data;
    } ppt_host_s;

endpackage

// File: design/ppt_port.sv
/*
 * Port-level file of the parallel port; it holds no definitions, as the timing,
 * address and status logic lives in ppt_core. Assumes nothing of its surroundings.
 */

// File: design/ppt_core.sv
/*
 * Parallel port master cycle timing, address register, pin functions and slave
 * buffer status. Assumes host strobes arrive from pins and are synchronised here.
 */

// Summary of operation
// - Strobe lasts strobe field plus one
// - Write hold lasts hold field plus one
// - Read hold lasts hold field cycles
// - Zero strobe field forces setup, hold defaults
// - Chip select bit never auto steps
// - Error interrupt ignores interrupt mode
// - Address bits 10..0, gaps read zero
// - Function 10: bit 14 drives chip select
// - Function 00/01: bit 14 is address
// - Bit 14 enable gives pin to port
// - Enables hand address pins 10..2 over
// - Pins 1..0 address or latch strobes
// - All-full flag set when every input full
// - Host overfill sets sticky overflow, error
// - Input full flags clear on read
// - All-empty flag, resets to one
// - Host empty read sets sticky underflow
// - Output empty flags clear on write
// - Status resets inputs zero, outputs one
// - Setup and address phase field plus one
// - Address steps up, down or holds
// - Mode 01 interrupts after each cycle
// - Mode field selects slave or master
module ppt_core #(
    parameter int NBUF = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire ppt_pkg::ppt_req_s busReq,
    output logic [31:0] busRdata,
    // Master cycle start from the rest of the port
    input wire logic cycleStart,
    input wire logic cycleIsWrite,
    // External host pins, slave modes
    input wire ppt_pkg::ppt_host_s hostPins,
    output logic [7:0] hostRdata,
    // Pins
    output logic [15:0] addrPinOut,
    output logic [15:0] addrPinOe,
    output logic strobeActive,
    output logic dataDrive,
    // Interrupts
    output logic portIrq,
    output logic portErrIrq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] modeReg;
    logic [31:0] addrReg;
    logic [31:0] penReg;
    logic [31:0] ctrlReg;
    logic [NBUF-1:0] inFullReg;
    logic [NBUF-1:0] outEmptyReg;
    logic inOvfReg;
    logic outUnfReg;
    logic [7:0] inBuf [NBUF];
    logic [7:0] outBuf [NBUF];
    ppt_pkg::ppt_state_e stateReg;
    logic [3:0] cntReg;
    logic writeCycReg;
    logic busyReg;

    logic [1:0] setupF;
    logic [3:0] strobeF;
    logic [1:0] holdF;
    logic [1:0] stepSel;
    logic [1:0] irqSel;
    logic [1:0] csfSel;
    logic [1:0] muxSel;
    ppt_pkg::ppt_mode_e portMode;
    logic isMaster;
    logic csMode;
    logic cycleEnd;

    assign setupF = modeReg[ppt_pkg::MODE_SETUP_LSB +: 2];
    assign strobeF = modeReg[ppt_pkg::MODE_STROBE_LSB +: 4];
    assign holdF = modeReg[ppt_pkg::MODE_HOLD_LSB +: 2];
    assign stepSel = modeReg[ppt_pkg::MODE_INC_LSB +: 2];
    assign irqSel = modeReg[ppt_pkg::MODE_IRQ_LSB +: 2];
    assign csfSel = ctrlReg[ppt_pkg::CTRL_CSF_LSB +: 2];
    assign muxSel = ctrlReg[ppt_pkg::CTRL_MUX_LSB +: 2];
    assign portMode = ppt_pkg::ppt_mode_e'(modeReg[ppt_pkg::MODE_MODE_LSB +: 2]);
    assign isMaster = (portMode == ppt_pkg::PPT_MASTER_SPLIT)
        || (portMode == ppt_pkg::PPT_MASTER_COMBINED);
    assign csMode = (csfSel == ppt_pkg::CSF_CHIPSEL);

    function automatic logic isWrite(input ppt_pkg::ppt_req_s r, input logic [3:0] idx);
        isWrite = r.wr && (r.addr == idx);
    endfunction

    // ------------------------------------------------------------
    // Host pin synchronisers
    // ------------------------------------------------------------
    ppt_pkg::ppt_host_s hostMeta;
    ppt_pkg::ppt_host_s hostSync;
    ppt_pkg::ppt_host_s hostPrev;
    logic hostWrPulse;
    logic hostRdPulse;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hostMeta <= '0;
            hostSync <= '0;
            hostPrev <= '0;
        end else begin
            hostMeta <= hostPins;
            hostSync <= hostMeta;
            hostPrev <= hostSync;
        end
    end

    // Edge detect on the second stage so each host strobe counts once
    assign hostWrPulse = hostSync.wr && !hostPrev.wr && !isMaster;
    assign hostRdPulse = hostSync.rd && !hostPrev.rd && !isMaster;

    // ------------------------------------------------------------
    // Master cycle sequencer
    // ------------------------------------------------------------
    logic [3:0] setupLen;
    logic [3:0] holdLen;
    logic needAddrPh;

    // Lengths minus one, so a phase lasts count plus one cycles
    always_comb begin
        setupLen = {2'b00, setupF};
        holdLen = writeCycReg ? {2'b00, holdF} : {2'b00, holdF} - 4'h1;
        if (strobeF == 4'h0) begin
            setupLen = 4'h0;
            holdLen = 4'h0;
        end
    end

    assign needAddrPh = (muxSel != ppt_pkg::MUX_NONE);
    assign cycleEnd = (stateReg == ppt_pkg::PPT_HOLD) && (cntReg == holdLen)
        || (stateReg == ppt_pkg::PPT_STROBE) && (cntReg == strobeF) && !writeCycReg
            && (strobeF == 4'h0 || holdF == 2'h0);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stateReg <= ppt_pkg::PPT_IDLE;
            cntReg <= 4'h0;
            writeCycReg <= 1'b0;
        end else begin
            cntReg <= cntReg + 4'h1;
            unique case (stateReg)
                ppt_pkg::PPT_IDLE: begin
                    cntReg <= 4'h0;
                    if (cycleStart && isMaster) begin
                        writeCycReg <= cycleIsWrite;
                        stateReg <= needAddrPh ? ppt_pkg::PPT_ADDRPH : ppt_pkg::PPT_SETUP;
                    end
                end
                ppt_pkg::PPT_ADDRPH: begin
                    if (cntReg == setupLen) begin
                        cntReg <= 4'h0;
                        stateReg <= ppt_pkg::PPT_SETUP;
                    end
                end
                ppt_pkg::PPT_SETUP: begin
                    if (cntReg == setupLen) begin
                        cntReg <= 4'h0;
                        stateReg <= ppt_pkg::PPT_STROBE;
                    end
                end
                ppt_pkg::PPT_STROBE: begin
                    if (cntReg == strobeF) begin
                        cntReg <= 4'h0;
                        // Reads with zero hold finish with the strobe
                        stateReg <= cycleEnd ? ppt_pkg::PPT_IDLE : ppt_pkg::PPT_HOLD;
                    end
                end
                ppt_pkg::PPT_HOLD: begin
                    if (cntReg == holdLen) begin
                        cntReg <= 4'h0;
                        stateReg <= ppt_pkg::PPT_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busyReg <= 1'b0;
        end else begin
            busyReg <= (stateReg != ppt_pkg::PPT_IDLE && !cycleEnd)
                || (stateReg == ppt_pkg::PPT_IDLE && cycleStart && isMaster);
        end
    end

    assign strobeActive = (stateReg == ppt_pkg::PPT_STROBE);
    assign dataDrive = writeCycReg && (stateReg == ppt_pkg::PPT_SETUP
        || stateReg == ppt_pkg::PPT_STROBE || stateReg == ppt_pkg::PPT_HOLD);

    // ------------------------------------------------------------
    // Register writes and address stepping
    // ------------------------------------------------------------
    logic [10:0] stepped;

    always_comb begin
        stepped = addrReg[10:0];
        if (stepSel == ppt_pkg::STEP_UP) begin
            stepped = addrReg[10:0] + 11'h004;
        end else if (stepSel == ppt_pkg::STEP_DOWN) begin
            stepped = addrReg[10:0] - 11'h004;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            modeReg <= '0;
            addrReg <= '0;
            penReg <= '0;
            ctrlReg <= '0;
        end else begin
            if (isWrite(busReq, ppt_pkg::IDX_MODE)) begin
                modeReg <= busReq.wdata & ppt_pkg::MODE_WMASK;
            end
            if (isWrite(busReq, ppt_pkg::IDX_PEN)) begin
                penReg <= busReq.wdata & ppt_pkg::PEN_WMASK;
            end
            if (isWrite(busReq, ppt_pkg::IDX_CTRL)) begin
                ctrlReg <= busReq.wdata & ppt_pkg::CTRL_WMASK;
            end
            if (isWrite(busReq, ppt_pkg::IDX_ADDR)) begin
                addrReg <= busReq.wdata & ppt_pkg::ADDR_WMASK;
            end else if (cycleEnd) begin
                // Bits 10..2 form the counter; bits 1..0 stay put
                addrReg[10:0] <= (stepped & ppt_pkg::STEP_MASK)
                    | (addrReg[10:0] & ~ppt_pkg::STEP_MASK);
                if (!csMode && ^stepSel) begin
                    addrReg[ppt_pkg::ADDR_BIT14] <= ~addrReg[ppt_pkg::ADDR_BIT14]
                        ^ 1'b1 ^ (stepSel == ppt_pkg::STEP_UP ? &addrReg[10:2]
                        : ~|addrReg[10:2]);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pin function
    // ------------------------------------------------------------
    always_comb begin
        addrPinOut = {1'b0, addrReg[14:0]};
        addrPinOe = {1'b0, penReg[14], 3'b000, penReg[10:2], 2'b00};
        addrPinOut[13:11] = 3'b000;
        // Chip select or address 14, as the function field picks
        addrPinOut[ppt_pkg::ADDR_BIT14] = addrReg[ppt_pkg::ADDR_BIT14];
        addrPinOe[1:0] = penReg[1:0];
        if (needAddrPh) begin
            // Latch strobes during the multiplexed address phase
            addrPinOut[1:0] = {2{stateReg == ppt_pkg::PPT_ADDRPH}};
        end
    end

    // ------------------------------------------------------------
    // Slave buffers and status
    // ------------------------------------------------------------
    logic [1:0] hostSel;
    logic [1:0] swSel;
    logic swInRead;
    logic swOutWrite;
    logic clrErr;

    assign hostSel = hostSync.sel;
    assign swSel = busReq.wdata[9:8];
    assign swInRead = busReq.rd && (busReq.addr == ppt_pkg::IDX_IBUF);
    assign swOutWrite = isWrite(busReq, ppt_pkg::IDX_OUTPUT_UNDERFLOW);
    assign clrErr = isWrite(busReq, ppt_pkg::IDX_STAT);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            inFullReg <= ppt_pkg::IFULL_RST;
            outEmptyReg <= ppt_pkg::OEMPTY_RST;
            inOvfReg <= 1'b0;
            outUnfReg <= 1'b0;
            for (int i = 0; i < NBUF; i++) begin
                inBuf[i] <= 8'h00;
                outBuf[i] <= 8'h00;
            end
        end else begin
            if (swInRead) begin
                inFullReg[busReq.wdata[1:0]] <= 1'b0;
            end
            if (swOutWrite) begin
                outBuf[swSel] <= busReq.wdata[7:0];
                outEmptyReg[swSel] <= 1'b0;
            end
            if (hostRdPulse && !outEmptyReg[hostSel]) begin
                outEmptyReg[hostSel] <= 1'b1;
            end
            if (hostWrPulse && !inFullReg[hostSel]) begin
                inBuf[hostSel] <= hostSync.data;
                inFullReg[hostSel] <= 1'b1;
            end
            // Clear by a zero write, but a same-cycle event wins
            if (clrErr && !busReq.wdata[ppt_pkg::STAT_IOVF]) begin
                inOvfReg <= 1'b0;
            end
            if (clrErr && !busReq.wdata[ppt_pkg::STAT_OUNF]) begin
                outUnfReg <= 1'b0;
            end
            if (hostWrPulse && inFullReg[hostSel]) begin
                inOvfReg <= 1'b1;
            end
            if (hostRdPulse && outEmptyReg[hostSel]) begin
                outUnfReg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hostRdata <= 8'h00;
        end else if (hostRdPulse) begin
            hostRdata <= outBuf[hostSel];
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            portIrq <= 1'b0;
            portErrIrq <= 1'b0;
        end else begin
            portIrq <= cycleEnd && (irqSel == ppt_pkg::IRQ_EACH);
            // Error path does not look at the interrupt mode
            portErrIrq <= (hostWrPulse && inFullReg[hostSel])
                || (hostRdPulse && outEmptyReg[hostSel]);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] statWord;

    always_comb begin
        statWord = '0;
        statWord[ppt_pkg::STAT_IALL] = &inFullReg;
        statWord[ppt_pkg::STAT_IOVF] = inOvfReg;
        statWord[ppt_pkg::STAT_IFULL_LSB +: NBUF] = inFullReg;
        statWord[ppt_pkg::STAT_OALL] = &outEmptyReg;
        statWord[ppt_pkg::STAT_OUNF] = outUnfReg;
        statWord[NBUF-1:0] = outEmptyReg;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busRdata <= '0;
        end else if (busReq.rd) begin
            unique case (busReq.addr)
                ppt_pkg::IDX_MODE: busRdata <= modeReg | ({31'h0, busyReg} << ppt_pkg::MODE_BUSY);
                ppt_pkg::IDX_ADDR: busRdata <= addrReg;
                ppt_pkg::IDX_PEN: busRdata <= penReg;
                ppt_pkg::IDX_STAT: busRdata <= statWord;
                ppt_pkg::IDX_CTRL: busRdata <= ctrlReg;
                ppt_pkg::IDX_IBUF: busRdata <= {24'h0, inBuf[busReq.wdata[1:0]]};
                default: busRdata <= '0;
            endcase
        end else begin
            busRdata <= '0;
        end
    end

endmodule

// File: bench/ppt_core_assertions.sv
/* Port checker of ppt_core, bound to every instance.
   Assumes one clock domain and reset active high. */
module ppt_core_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire ppt_pkg::ppt_req_s busReq,
    input wire logic [31:0] busRdata,
    // Pins and events
    input wire logic [15:0] addrPinOe,
    input wire logic strobeActive,
    input wire logic dataDrive,
    input wire logic portIrq,
    input wire logic portErrIrq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    logic [4:0] strobeLen;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            strobeLen <= 5'h00;
        else
            strobeLen <= strobeActive ? strobeLen + 5'h01 : 5'h00;
    end

    property p_rdata_idle;
        !$past(busReq.rd) |-> busRdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");
    property p_addr_gaps;
        $past(busReq.rd) && $past(busReq.addr) == ppt_pkg::IDX_ADDR
            |-> busRdata[31:15] == '0 && busRdata[13:11] == '0;
    endproperty
    a_addr_gaps: assert property (p_addr_gaps) else $error("address gap bits set");
    property p_all_full;
        $past(busReq.rd) && $past(busReq.addr) == ppt_pkg::IDX_STAT
            |-> busRdata[15] == &busRdata[11:8];
    endproperty
    a_all_full: assert property (p_all_full) else $error("all-full flag wrong");
    property p_all_empty;
        $past(busReq.rd) && $past(busReq.addr) == ppt_pkg::IDX_STAT
            |-> busRdata[7] == &busRdata[3:0];
    endproperty
    a_all_empty: assert property (p_all_empty) else $error("all-empty flag wrong");
    property p_strobe_max;
        strobeActive |-> strobeLen < 5'h10;
    endproperty
    a_strobe_max: assert property (p_strobe_max) else $error("strobe too long");
    property p_write_hold;
        $fell(strobeActive) && $past(dataDrive) |-> dataDrive;
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("write data not held");
    property p_setup;
        $rose(strobeActive) && dataDrive |-> $past(dataDrive);
    endproperty
    a_setup: assert property (p_setup) else $error("no data setup");
    property p_irq_after;
        portIrq |-> !strobeActive ##1 !portIrq;
    endproperty
    a_irq_after: assert property (p_irq_after) else $error("irq inside cycle");
    property p_err_pulse;
        portErrIrq |=> !portErrIrq;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("error irq too long");
    property p_pen_lines;
        busReq.wr && busReq.addr == ppt_pkg::IDX_PEN
            |=> addrPinOe[10:2] == $past(busReq.wdata[10:2]);
    endproperty
    a_pen_lines: assert property (p_pen_lines) else $error("address pin enable");
    property p_pen_top;
        busReq.wr && busReq.addr == ppt_pkg::IDX_PEN |=> addrPinOe[14] == $past(busReq.wdata[14]);
    endproperty
    a_pen_top: assert property (p_pen_top) else $error("bit 14 pin enable");
endmodule

bind ppt_core ppt_core_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .busReq(busReq),
    .busRdata(busRdata), .addrPinOe(addrPinOe), .strobeActive(strobeActive),
    .dataDrive(dataDrive), .portIrq(portIrq), .portErrIrq(portErrIrq));

// File: bench/ppt_host_model.sv
/* External host on the slave pins of ppt_core.
   Assumes the bench calls hostAccess one at a time. */
module ppt_host_model (
    // Clock
    input wire logic clk_sys,
    // Host pins
    output ppt_pkg::ppt_host_s pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = '0;
    // Four cycles each way so the two-flop synchroniser sees every edge
    task automatic hostAccess(input logic isWr, input logic [1:0] sel, input logic [7:0] data);
        @(posedge clk_sys);
        pins <= '{wr: isWr, rd: !isWr, sel: sel, data: data};
        repeat (4) @(posedge clk_sys);
        pins <= '{wr: 1'b0, rd: 1'b0, sel: ~sel, data: ~data};
        repeat (4) @(posedge clk_sys);
    endtask
endmodule

// File: bench/testbench.sv
/* Self-checking bench of ppt_core.
   Assumes the host model and the bound port checker. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    ppt_pkg::ppt_req_s busReq = '0;
    logic cycleStart = 1'b0;
    logic cycleIsWrite = 1'b0;
    ppt_pkg::ppt_host_s hostPins;
    logic [31:0] busRdata;
    logic [31:0] q;
    logic [7:0] hostRdata;
    logic [15:0] addrPinOut;
    logic [15:0] addrPinOe;
    logic strobeActive, dataDrive, portIrq, portErrIrq;
    int errCount = 0;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    ppt_core u_dut (.clk_sys(clk_sys), .rst(rst), .busReq(busReq), .busRdata(busRdata),
        .cycleStart(cycleStart), .cycleIsWrite(cycleIsWrite), .hostPins(hostPins),
        .hostRdata(hostRdata), .addrPinOut(addrPinOut), .addrPinOe(addrPinOe),
        .strobeActive(strobeActive), .dataDrive(dataDrive), .portIrq(portIrq),
        .portErrIrq(portErrIrq));
    ppt_host_model u_host (.clk_sys(clk_sys), .pins(hostPins));

    always @(posedge clk_sys) begin
        cycles++;
        if (portErrIrq === 1'b1) errCount++;
        if (cycles > 20000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic busWr(input logic [3:0] a, input logic [31:0] d);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        busReq <= '0;
        @(posedge clk_sys);
    endtask

    task automatic busRd(input logic [3:0] a, input logic [31:0] d);
        busReq <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        busReq <= '0;
        #1 q = busRdata;
        @(posedge clk_sys);
    endtask

    // Counts lead-in, strobe and tail cycles up to the end-of-cycle interrupt
    task automatic runCycle(input logic w, input logic [31:0] m, output int p, s, t);
        busWr(ppt_pkg::IDX_MODE, m);
        cycleStart <= 1'b1;
        cycleIsWrite <= w;
        @(posedge clk_sys);
        cycleStart <= 1'b0;
        p = 0; s = 0; t = 0;
        repeat (200) begin
            @(posedge clk_sys);
            #1;
            if (portIrq === 1'b1) break;
            if (strobeActive === 1'b1) s++;
            else if (s == 0) p++;
            else t++;
        end
        @(posedge clk_sys);
    endtask

    task automatic checkRegs();
        busRd(ppt_pkg::IDX_STAT, 0);
        `CHK(q, 32'h0000_008f);
        busWr(ppt_pkg::IDX_ADDR, 32'hffff_ffff);
        busRd(ppt_pkg::IDX_ADDR, 0);
        `CHK(q, 32'h0000_47ff);
        busWr(4'hf, 32'hffff_ffff);
        busRd(4'hf, 0);
        `CHK(q, 32'h0000_0000);
    endtask

    task automatic checkTiming();
        logic [31:0] m[5] = '{32'h0000_220c, 32'h0000_22ff, 32'h0000_22ff, 32'h0000_22c3,
            32'h0000_23c3};
        int p[5], s[5], t[5];
        for (int i = 0; i < 5; i++) runCycle(i != 2 && i != 4, m[i], p[i], s[i], t[i]);
        `CHK(s[0], 4);
        `CHK(s[1], 16);
        `CHK(p[1], p[0] + 3);
        `CHK(t[1], t[0] + 3);
        `CHK(t[2], t[1] - 1);
        `CHK(s[3], 1);
        `CHK(t[3], t[0]);
        `CHK(p[3], p[0]);
        `CHK(t[4], t[0] - 1);
    endtask

    task automatic checkAddress();
        int p, s, t;
        busWr(ppt_pkg::IDX_PEN, 32'h0000_4007);
        busWr(ppt_pkg::IDX_CTRL, 32'h0000_0080);
        busWr(ppt_pkg::IDX_ADDR, 32'h0000_47fc);
        `CHK(addrPinOe, 16'h4007);
        `CHK(addrPinOut[14], 1'b1);
        runCycle(1'b1, 32'h0000_2a00, p, s, t);
        busRd(ppt_pkg::IDX_ADDR, 0);
        `CHK(q, 32'h0000_4000);
        busWr(ppt_pkg::IDX_CTRL, 32'h0000_0000);
        busWr(ppt_pkg::IDX_ADDR, 32'h0000_47fc);
        runCycle(1'b1, 32'h0000_2a00, p, s, t);
        busRd(ppt_pkg::IDX_ADDR, 0);
        `CHK(q, 32'h0000_0000);
        runCycle(1'b0, 32'h0000_3200, p, s, t);
        busRd(ppt_pkg::IDX_ADDR, 0);
        `CHK(q, 32'h0000_47fc);
        `CHK(addrPinOut[14], 1'b1);
        busWr(ppt_pkg::IDX_CTRL, 32'h0000_0800);
        runCycle(1'b1, 32'h0000_22c4, p, s, t);
        `CHK(p, 7);
        `CHK(s, 2);
    endtask

    task automatic checkSlave();
        busWr(ppt_pkg::IDX_MODE, 0);
        for (int i = 0; i < 4; i++) u_host.hostAccess(1'b1, i[1:0], 8'h50 + 8'(i));
        busRd(ppt_pkg::IDX_STAT, 0);
        `CHK(q, 32'h0000_8f8f);
        `CHK(errCount, 0);
        u_host.hostAccess(1'b1, 2'h0, 8'h99);
        busRd(ppt_pkg::IDX_STAT, 0);
        `CHK(q, 32'h0000_cf8f);
        `CHK(errCount, 1);
        busRd(ppt_pkg::IDX_IBUF, 32'h0000_0002);
        `CHK(q, 32'h0000_0052);
        busWr(ppt_pkg::IDX_STAT, 0);
        busWr(ppt_pkg::IDX_OUTPUT_UNDERFLOW, 32'h0000_0177);
        busRd(ppt_pkg::IDX_STAT, 0);
        `CHK(q, 32'h0000_0b0d);
        u_host.hostAccess(1'b0, 2'h3, 8'h00);
        busRd(ppt_pkg::IDX_STAT, 0);
        `CHK(q, 32'h0000_0b4d);
        `CHK(errCount, 2);
        u_host.hostAccess(1'b0, 2'h1, 8'h00);
        `CHK(hostRdata, 8'h77);
        busRd(ppt_pkg::IDX_STAT, 0);
        `CHK(q, 32'h0000_0bcf);
        `CHK(errCount, 2);
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        checkRegs();
        checkTiming();
        checkAddress();
        checkSlave();
        print_verdict();
    end
endmodule
